/* File: design/ufts_cfg.svh */
// register map, field positions, reset values and sizes of the uart threshold status block
`ifndef UFTS_CFG_SVH
`define UFTS_CFG_SVH

`define UFTS_DEPTH 4'h8
`define UFTS_ADDR_STATUS_HIGH 8'h00
`define UFTS_ADDR_MODE_CTRL 8'h04
`define UFTS_ADDR_IRQ_STATUS 8'h08
`define UFTS_ADDR_IRQ_MASK 8'h0c
`define UFTS_ADDR_OCCUPANCY 8'h10

`define UFTS_TXSEL_HI 14
`define UFTS_TXSEL_LO 12
`define UFTS_RXSEL_HI 10
`define UFTS_RXSEL_LO 8
`define UFTS_TX_WRITE_ERROR_FLAG_BIT 7
`define UFTS_STOP_DETECT_MODE_BIT 6
`define UFTS_TXBE_BIT 5
`define UFTS_TXBF_BIT 4
`define UFTS_RXBE_BIT 1
`define UFTS_RXBF_BIT 0

`define UFTS_MODE_HI 1
`define UFTS_MODE_LO 0
`define UFTS_PARITY_ERROR_FLAG_IE_BIT 4
`define UFTS_FRAMING_ERROR_FLAG_IE_BIT 5

`define UFTS_EV_TX 0
`define UFTS_EV_RX 1
`define UFTS_EV_WRE 2
`define UFTS_EV_W 3

`define UFTS_OCC_TX_LO 0
`define UFTS_OCC_RX_LO 8

`define UFTS_SEL_RESET 3'h0
`define UFTS_EV_RESET 3'h0
`define UFTS_RDATA_RESET 32'h0000_0000

`endif

/* File: design/ufts_pkg.sv */
// types and shared arithmetic of the uart threshold status block
`include "ufts_cfg.svh"

package ufts_pkg;
    typedef logic [3:0] ufts_cnt_t;
    typedef logic [2:0] ufts_sel_t;

    typedef enum logic [1:0] {
        UFTS_MODE_OTHER,
        UFTS_MODE_LIN_PARITY,
        UFTS_MODE_ADDR_DETECT,
        UFTS_MODE_SPARE
    } ufts_mode_e;

    typedef enum logic {
        UFTS_BUS_IDLE,
        UFTS_BUS_ACK
    } ufts_bus_e;

    typedef struct packed {
        logic read;
        logic write;
        logic [7:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } ufts_av_req_s;

    // occupancy and write strobes from the surrounding uart, same clock
    typedef struct packed {
        ufts_cnt_t tx_count;
        ufts_cnt_t rx_count;
        logic tx_wr;
        logic p1_wr;
        logic p1_full;
        logic p2_zero;
        logic parity_error_flag;
        logic framing_error_flag;
    } ufts_buf_s;

    // empty slots reach 8 - sel: 000 -> 8, 001 -> 7, 010 -> 6, 111 -> 1
    function automatic logic ufts_tx_hit(input ufts_sel_t sel, input ufts_cnt_t used);
        ufts_cnt_t empty;
        ufts_cnt_t need;
        empty = 4'(`UFTS_DEPTH - used);
        need = 4'(`UFTS_DEPTH - {1'b0, sel});
        return empty >= need;
    endfunction

    // held bytes reach sel + 1
    function automatic logic ufts_rx_hit(input ufts_sel_t sel, input ufts_cnt_t used);
        return used >= 4'({1'b0, sel} + 4'h1);
    endfunction

    function automatic logic [31:0] ufts_be_merge(input logic [31:0] old_v,
                                                  input logic [31:0] new_v,
                                                  input logic [3:0] be);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction
endpackage

/* File: design/ufts_thresh.sv */
// registered transmit and receive threshold comparators
`timescale 1ns/100ps

module ufts_thresh (
    input wire logic mclk,
    input wire logic arst_n,
    input wire ufts_pkg::ufts_sel_t tx_sel,
    input wire ufts_pkg::ufts_sel_t rx_sel,
    input wire ufts_pkg::ufts_buf_s buf_st,
    input wire logic parity_error_flag_ie,
    input wire logic framing_error_flag_ie,
    output logic tx_hit_reg,
    output logic rx_hit_reg
);
    import ufts_pkg::*;

    logic tx_hit_next;
    logic rx_hit_next;
    logic rx_blocked;

    // compared every cycle so the request tracks occupancy one clock late at most
    always_comb begin
        rx_blocked = (buf_st.parity_error_flag && parity_error_flag_ie) ||
                     (buf_st.framing_error_flag && framing_error_flag_ie);
        tx_hit_next = ufts_tx_hit(tx_sel, buf_st.tx_count);
        rx_hit_next = ufts_rx_hit(rx_sel, buf_st.rx_count) && !rx_blocked;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tx_hit_reg <= 1'b0;
            rx_hit_reg <= 1'b0;
        end else begin
            tx_hit_reg <= tx_hit_next;
            rx_hit_reg <= rx_hit_next;
        end
    end
endmodule

/* File: design/ufts_top.sv */
// uart high status register, threshold interrupts and write error flag behind avalon-mm
`timescale 1ns/100ps
`include "ufts_cfg.svh"

module ufts_top (
    input wire logic mclk,
    input wire logic arst_n,
    input wire ufts_pkg::ufts_av_req_s av_req,
    output logic [31:0] av_readdata,
    output logic av_waitrequest,
    input wire ufts_pkg::ufts_buf_s buf_st,
    output logic tx_irq,
    output logic rx_irq,
    output logic tx_write_error_flag,
    output logic irq
);
    import ufts_pkg::*;

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    ufts_bus_e bus_reg, bus_next;
    logic wait_reg, wait_next;
    logic [31:0] rdata_reg, rdata_next;
    ufts_sel_t tx_irq_threshold_sel_reg, tx_irq_threshold_sel_next;
    ufts_sel_t rx_irq_threshold_sel_reg, rx_irq_threshold_sel_next;
    logic stop_detect_mode_reg, stop_detect_mode_next;
    logic tx_write_error_flag_reg, tx_write_error_flag_next;
    ufts_mode_e mode_reg, mode_next;
    logic parity_error_flag_ie_reg, parity_error_flag_ie_next;
    logic framing_error_flag_ie_reg, framing_error_flag_ie_next;
    logic [`UFTS_EV_W-1:0] ev_reg, ev_next;
    logic [`UFTS_EV_W-1:0] mask_reg, mask_next;
    logic irq_reg, irq_next;

    logic tx_hit;
    logic rx_hit;
    logic wr_commit;
    logic wre_event;
    logic tx_full;
    logic [31:0] wdata_eff;
    logic [31:0] status_word;

    ufts_thresh u_thresh (
        .mclk(mclk),
        .arst_n(arst_n),
        .tx_sel(tx_irq_threshold_sel_reg),
        .rx_sel(rx_irq_threshold_sel_reg),
        .buf_st(buf_st),
        .parity_error_flag_ie(parity_error_flag_ie_reg),
        .framing_error_flag_ie(framing_error_flag_ie_reg),
        .tx_hit_reg(tx_hit),
        .rx_hit_reg(rx_hit)
    );

    // ------------------------------------------------------------
    // bus slave: one wait cycle, then a one-cycle answer
    // ------------------------------------------------------------
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`UFTS_TXSEL_HI:`UFTS_TXSEL_LO] = tx_irq_threshold_sel_reg;
        status_word[`UFTS_RXSEL_HI:`UFTS_RXSEL_LO] = rx_irq_threshold_sel_reg;
        status_word[`UFTS_TX_WRITE_ERROR_FLAG_BIT] = tx_write_error_flag_reg;
        status_word[`UFTS_STOP_DETECT_MODE_BIT] = stop_detect_mode_reg;
        status_word[`UFTS_TXBE_BIT] = (buf_st.tx_count == 4'h0);
        status_word[`UFTS_TXBF_BIT] = tx_full;
        status_word[`UFTS_RXBE_BIT] = (buf_st.rx_count == 4'h0);
        status_word[`UFTS_RXBF_BIT] = (buf_st.rx_count == `UFTS_DEPTH);
    end

    always_comb begin
        bus_next = bus_reg;
        wait_next = 1'b1;
        rdata_next = rdata_reg;
        case (bus_reg)
            UFTS_BUS_IDLE: begin
                if (av_req.read || av_req.write) begin
                    bus_next = UFTS_BUS_ACK;
                    wait_next = 1'b0;
                    rdata_next = `UFTS_RDATA_RESET;
                    if (av_req.address == `UFTS_ADDR_STATUS_HIGH) begin
                        rdata_next = status_word;
                    end else if (av_req.address == `UFTS_ADDR_MODE_CTRL) begin
                        rdata_next[`UFTS_MODE_HI:`UFTS_MODE_LO] = mode_reg;
                        rdata_next[`UFTS_PARITY_ERROR_FLAG_IE_BIT] = parity_error_flag_ie_reg;
                        rdata_next[`UFTS_FRAMING_ERROR_FLAG_IE_BIT] = framing_error_flag_ie_reg;
                    end else if (av_req.address == `UFTS_ADDR_IRQ_STATUS) begin
                        rdata_next[`UFTS_EV_W-1:0] = ev_reg;
                    end else if (av_req.address == `UFTS_ADDR_IRQ_MASK) begin
                        rdata_next[`UFTS_EV_W-1:0] = mask_reg;
                    end else if (av_req.address == `UFTS_ADDR_OCCUPANCY) begin
                        rdata_next[`UFTS_OCC_TX_LO +: 4] = buf_st.tx_count;
                        rdata_next[`UFTS_OCC_RX_LO +: 4] = buf_st.rx_count;
                    end
                end
            end
            UFTS_BUS_ACK: begin
                bus_next = UFTS_BUS_IDLE;
            end
            default: begin
                bus_next = UFTS_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            bus_reg <= UFTS_BUS_IDLE;
            wait_reg <= 1'b1;
            rdata_reg <= `UFTS_RDATA_RESET;
        end else begin
            bus_reg <= bus_next;
            wait_reg <= wait_next;
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // register writes and event flags
    // ------------------------------------------------------------
    // writes land on the edge where waitrequest is seen low
    assign wr_commit = (bus_reg == UFTS_BUS_ACK) && av_req.write;
    assign tx_full = (buf_st.tx_count == `UFTS_DEPTH);

    always_comb begin
        case (mode_reg)
            UFTS_MODE_LIN_PARITY: begin
                wre_event = buf_st.tx_wr && (tx_full || buf_st.p2_zero);
            end
            UFTS_MODE_ADDR_DETECT: begin
                wre_event = (buf_st.tx_wr && tx_full) ||
                            (buf_st.p1_wr && buf_st.p1_full);
            end
            default: begin
                wre_event = buf_st.tx_wr && tx_full;
            end
        endcase
    end

    always_comb begin
        tx_irq_threshold_sel_next = tx_irq_threshold_sel_reg;
        rx_irq_threshold_sel_next = rx_irq_threshold_sel_reg;
        stop_detect_mode_next = stop_detect_mode_reg;
        tx_write_error_flag_next = tx_write_error_flag_reg;
        mode_next = mode_reg;
        parity_error_flag_ie_next = parity_error_flag_ie_reg;
        framing_error_flag_ie_next = framing_error_flag_ie_reg;
        ev_next = ev_reg;
        mask_next = mask_reg;
        wdata_eff = 32'h0000_0000;
        if (wr_commit) begin
            if (av_req.address == `UFTS_ADDR_STATUS_HIGH) begin
                wdata_eff = ufts_be_merge(status_word, av_req.writedata, av_req.byteenable);
                tx_irq_threshold_sel_next = wdata_eff[`UFTS_TXSEL_HI:`UFTS_TXSEL_LO];
                rx_irq_threshold_sel_next = wdata_eff[`UFTS_RXSEL_HI:`UFTS_RXSEL_LO];
                stop_detect_mode_next = wdata_eff[`UFTS_STOP_DETECT_MODE_BIT];
                // software may only clear the error flag by writing a zero
                tx_write_error_flag_next = tx_write_error_flag_reg && wdata_eff[`UFTS_TX_WRITE_ERROR_FLAG_BIT];
            end else if (av_req.address == `UFTS_ADDR_MODE_CTRL) begin
                wdata_eff = ufts_be_merge(32'h0000_0000, av_req.writedata, av_req.byteenable);
                mode_next = ufts_mode_e'(wdata_eff[`UFTS_MODE_HI:`UFTS_MODE_LO]);
                parity_error_flag_ie_next = wdata_eff[`UFTS_PARITY_ERROR_FLAG_IE_BIT];
                framing_error_flag_ie_next = wdata_eff[`UFTS_FRAMING_ERROR_FLAG_IE_BIT];
            end else if (av_req.address == `UFTS_ADDR_IRQ_STATUS) begin
                if (av_req.byteenable[0]) begin
                    ev_next = ev_reg & ~av_req.writedata[`UFTS_EV_W-1:0];
                end
            end else if (av_req.address == `UFTS_ADDR_IRQ_MASK) begin
                if (av_req.byteenable[0]) begin
                    mask_next = av_req.writedata[`UFTS_EV_W-1:0];
                end
            end
        end
        // a new event in the clearing cycle survives: set wins
        if (wre_event) begin
            tx_write_error_flag_next = 1'b1;
        end
        ev_next[`UFTS_EV_TX] = ev_next[`UFTS_EV_TX] | tx_hit;
        ev_next[`UFTS_EV_RX] = ev_next[`UFTS_EV_RX] | rx_hit;
        ev_next[`UFTS_EV_WRE] = ev_next[`UFTS_EV_WRE] | wre_event;
        irq_next = |(ev_next & mask_next);
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tx_irq_threshold_sel_reg <= `UFTS_SEL_RESET;
            rx_irq_threshold_sel_reg <= `UFTS_SEL_RESET;
            stop_detect_mode_reg <= 1'b0;
            tx_write_error_flag_reg <= 1'b0;
            mode_reg <= UFTS_MODE_OTHER;
            parity_error_flag_ie_reg <= 1'b0;
            framing_error_flag_ie_reg <= 1'b0;
            ev_reg <= `UFTS_EV_RESET;
            mask_reg <= `UFTS_EV_RESET;
            irq_reg <= 1'b0;
        end else begin
            tx_irq_threshold_sel_reg <= tx_irq_threshold_sel_next;
            rx_irq_threshold_sel_reg <= rx_irq_threshold_sel_next;
            stop_detect_mode_reg <= stop_detect_mode_next;
            tx_write_error_flag_reg <= tx_write_error_flag_next;
            mode_reg <= mode_next;
            parity_error_flag_ie_reg <= parity_error_flag_ie_next;
            framing_error_flag_ie_reg <= framing_error_flag_ie_next;
            ev_reg <= ev_next;
            mask_reg <= mask_next;
            irq_reg <= irq_next;
        end
    end

    assign av_readdata = rdata_reg;
    assign av_waitrequest = wait_reg;
    assign tx_irq = tx_hit;
    assign rx_irq = rx_hit;
    assign tx_write_error_flag = tx_write_error_flag_reg;
    assign irq = irq_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    a_tx_one_slot: assert property (
        (tx_irq_threshold_sel_reg == 3'h7 && buf_st.tx_count <= 4'h7) |=> tx_irq)
        else $error("tx irq missing with one empty slot");
    a_tx_six_slots: assert property (
        (tx_irq_threshold_sel_reg == 3'h2) |=> (tx_irq == ($past(buf_st.tx_count) <= 4'h2)))
        else $error("tx irq wrong at six slot threshold");
    a_tx_seven_slots: assert property (
        (tx_irq_threshold_sel_reg == 3'h1 && buf_st.tx_count == 4'h2) |=> !tx_irq)
        else $error("tx irq raised below seven empty slots");
    a_tx_all_empty: assert property (
        (tx_irq_threshold_sel_reg == 3'h0) |=> (tx_irq == ($past(buf_st.tx_count) == 4'h0)))
        else $error("tx irq wrong for empty buffer select");
    a_rx_two_bytes: assert property (
        (rx_irq_threshold_sel_reg == 3'h1 && !parity_error_flag_ie_reg && !framing_error_flag_ie_reg)
        |=> (rx_irq == ($past(buf_st.rx_count) >= 4'h2)))
        else $error("rx irq wrong at two byte threshold");
    a_rx_one_byte: assert property (
        (rx_irq_threshold_sel_reg == 3'h0 && buf_st.rx_count == 4'h0) |=> !rx_irq)
        else $error("rx irq raised with empty buffer");
    a_lin_wr_error: assert property (
        (mode_reg == UFTS_MODE_LIN_PARITY && buf_st.tx_wr && buf_st.p2_zero)
        |=> tx_write_error_flag)
        else $error("write error not flagged for zero parameter");
    a_addr_wr_error: assert property (
        (mode_reg == UFTS_MODE_ADDR_DETECT && buf_st.p1_wr && buf_st.p1_full)
        |=> tx_write_error_flag)
        else $error("write error not flagged for full first parameter");
    a_wre_sticky: assert property (
        (tx_write_error_flag && !wr_commit) |=> tx_write_error_flag)
        else $error("write error flag dropped without software clear");
    a_rx_blocked: assert property (
        (buf_st.parity_error_flag && parity_error_flag_ie_reg) |=> !rx_irq)
        else $error("rx irq raised during enabled parity error");
    a_bus_answer: assert property (
        (bus_reg == UFTS_BUS_IDLE && (av_req.read || av_req.write))
        |=> !av_waitrequest ##1 av_waitrequest)
        else $error("bus answer not one cycle after request");
    a_rx_one_hit: assert property (
        (rx_irq_threshold_sel_reg == 3'h0 && !parity_error_flag_ie_reg && !framing_error_flag_ie_reg &&
         buf_st.rx_count != 4'h0) |=> rx_irq)
        else $error("rx irq missing with bytes held");
    a_rx_frame_block: assert property (
        (buf_st.framing_error_flag && framing_error_flag_ie_reg) |=> !rx_irq)
        else $error("rx irq raised during enabled framing error");
    a_tx_full_none: assert property (
        (buf_st.tx_count == `UFTS_DEPTH) |=> !tx_irq)
        else $error("tx irq raised with no empty slot");
    a_full_wr_error: assert property (
        (buf_st.tx_wr && tx_full) |=> tx_write_error_flag)
        else $error("write error not flagged for full buffer");
    // software clears the flag only through a zero in its status bit
    a_wre_clear: assert property (
        (wr_commit && av_req.address == `UFTS_ADDR_STATUS_HIGH && av_req.byteenable[0] &&
         !av_req.writedata[`UFTS_TX_WRITE_ERROR_FLAG_BIT] && !wre_event) |=> !tx_write_error_flag)
        else $error("write error flag not cleared by software");
    a_wait_single: assert property (
        !av_waitrequest |=> av_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_idle_wait: assert property (
        (bus_reg == UFTS_BUS_IDLE) |-> av_waitrequest)
        else $error("waitrequest low while bus idle");
    // read data may only move on the edge that opens an answer cycle
    a_rdata_hold: assert property (
        av_waitrequest |-> $stable(av_readdata))
        else $error("read data changed outside an answer");

    c_tx_irq: cover property ($rose(tx_irq));
    c_rx_blocked: cover property (buf_st.framing_error_flag && framing_error_flag_ie_reg && buf_st.rx_count != 4'h0);
    c_wre_clear_race: cover property (wr_commit && wre_event);
    c_irq_out: cover property ($rose(irq));
    c_flag_clear: cover property ($fell(tx_write_error_flag));
endmodule

/* File: testbench/ufts_top_tb_top.sv */
// self-checking bench for the uart threshold status block
`timescale 1ns/100ps
`include "ufts_cfg.svh"

module ufts_top_tb_top;
    import ufts_pkg::*;
    logic mclk;
    logic arst_n;
    ufts_av_req_s av_req;
    logic [31:0] av_readdata;
    logic av_waitrequest;
    ufts_buf_s buf_st;
    logic tx_irq;
    logic rx_irq;
    logic tx_write_error_flag;
    logic irq;
    integer seed = 11336;
    int miscompares = 0;
    int compares = 0;
    logic [31:0] rd;
    ufts_sel_t ts;
    ufts_sel_t rs;
    logic pie;
    logic fie;
    logic [1:0] md;
    logic ew;
    ufts_sel_t tx_tab [4] = '{3'h0, 3'h1, 3'h2, 3'h7};

    ufts_top i_dut (
        .mclk(mclk),
        .arst_n(arst_n),
        .av_req(av_req),
        .av_readdata(av_readdata),
        .av_waitrequest(av_waitrequest),
        .buf_st(buf_st),
        .tx_irq(tx_irq),
        .rx_irq(rx_irq),
        .tx_write_error_flag(tx_write_error_flag),
        .irq(irq)
    );

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // expectation functions
    // ------------------------------------------------------------
    function automatic logic exp_tx(input ufts_sel_t sel, input ufts_cnt_t used);
        int empty;
        empty = 8 - int'(used);
        case (sel)
            3'h0: return empty >= 8;
            3'h1: return empty >= 7;
            3'h2: return empty >= 6;
            default: return empty >= 1;
        endcase
    endfunction

    // an enabled parity or framing error hides the rx threshold
    function automatic logic exp_rx(input ufts_sel_t sel, input ufts_buf_s b, input logic pe,
                                    input logic fe);
        if ((b.parity_error_flag && pe) || (b.framing_error_flag && fe)) begin
            return 1'b0;
        end
        return (sel == 3'h0) ? (b.rx_count >= 4'h1) : (b.rx_count >= 4'h2);
    endfunction

    function automatic logic exp_err(input logic [1:0] mode, input ufts_buf_s b);
        logic full;
        full = (b.tx_count == 4'h8);
        case (mode)
            2'h1: return b.tx_wr && (full || b.p2_zero);
            2'h2: return (b.tx_wr && full) || (b.p1_wr && b.p1_full);
            default: return b.tx_wr && full;
        endcase
    endfunction

    // buffer empty and full bits of the status word
    function automatic logic [31:0] exp_sta(input ufts_buf_s b);
        return (32'(b.tx_count == 4'h0) << 5) | (32'(b.tx_count == 4'h8) << 4) |
               (32'(b.rx_count == 4'h0) << 1) | 32'(b.rx_count == 4'h8);
    endfunction

    // ------------------------------------------------------------
    // reporting
    // ------------------------------------------------------------
    task automatic complete_run;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // ------------------------------------------------------------
    // avalon-mm master: hold until waitrequest is sampled low
    // ------------------------------------------------------------
    task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        int n;
        @(posedge mclk);
        av_req <= '{read: !wr, write: wr, address: addr, byteenable: 4'hf, writedata: wdata};
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (av_waitrequest !== 1'b0 && n < 20);
        rd = av_readdata;
        av_req <= '0;
        if (av_waitrequest !== 1'b0) begin
            miscompares++;
            $display("CHECK FAILED bus answer expected 0 seen 1");
            complete_run();
        end
    endtask

    task automatic settle;
        @(posedge mclk);
        @(negedge mclk);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        arst_n = 1'b0;
        av_req = '0;
        buf_st = '0;
        @(negedge mclk);
        check("wait in reset", 32'(av_waitrequest), 32'h1);
        check("rdata in reset", av_readdata, 32'h0);
        check("flag in reset", 32'(tx_write_error_flag), 32'h0);
        check("irq in reset", 32'(irq), 32'h0);
        @(posedge mclk);
        arst_n <= 1'b1;
        settle();
        check("tx irq empty", 32'(tx_irq), 32'h1);
        check("rx irq none", 32'(rx_irq), 32'h0);
        bus(1'b0, `UFTS_ADDR_STATUS_HIGH, 32'h0);
        check("status reset", rd, 32'h0000_0022);
        bus(1'b0, 8'h14, 32'h0);
        check("unmapped read", rd, 32'h0);

        // thresholds against random occupancy, hand corners first
        for (int i = 0; i < 40; i++) begin
            ts = tx_tab[$unsigned($random(seed)) % 4];
            rs = 3'($unsigned($random(seed)) % 2);
            pie = 1'($random(seed));
            fie = 1'($random(seed));
            bus(1'b1, `UFTS_ADDR_STATUS_HIGH,
                32'h80 | (32'(ts) << 12) | (32'(rs) << 8) | (32'(pie) << 6));
            bus(1'b1, `UFTS_ADDR_MODE_CTRL, (32'(fie) << 5) | (32'(pie) << 4));
            bus(1'b0, `UFTS_ADDR_STATUS_HIGH, 32'h0);
            check("select fields", rd, (32'(ts) << 12) | (32'(rs) << 8) | (32'(pie) << 6) |
                  exp_sta(buf_st));
            for (int j = 0; j < 9; j++) begin
                @(posedge mclk);
                buf_st.tx_count <= (i < 4) ? 4'(j) : 4'($unsigned($random(seed)) % 9);
                buf_st.rx_count <= (i < 4) ? 4'(8 - j) : 4'($unsigned($random(seed)) % 9);
                buf_st.parity_error_flag <= 1'($random(seed));
                buf_st.framing_error_flag <= 1'($random(seed));
                settle();
                check("tx irq", 32'(tx_irq), 32'(exp_tx(ts, buf_st.tx_count)));
                check("rx irq", 32'(rx_irq), 32'(exp_rx(rs, buf_st, pie, fie)));
            end
        end
        bus(1'b0, `UFTS_ADDR_OCCUPANCY, 32'h0);
        check("occupancy", rd, (32'(buf_st.rx_count) << 8) | 32'(buf_st.tx_count));

        // write error flag in every mode, with a software clear before each
        for (int i = 0; i < 48; i++) begin
            md = 2'(i % 4);
            bus(1'b1, `UFTS_ADDR_MODE_CTRL, 32'(md));
            bus(1'b1, `UFTS_ADDR_STATUS_HIGH, 32'h0);
            @(negedge mclk);
            check("flag cleared", 32'(tx_write_error_flag), 32'h0);
            @(posedge mclk);
            buf_st.tx_count <= $random(seed) ? 4'h8 : 4'($unsigned($random(seed)) % 9);
            buf_st.tx_wr <= 1'($random(seed));
            buf_st.p1_wr <= 1'($random(seed));
            buf_st.p1_full <= 1'($random(seed));
            buf_st.p2_zero <= 1'($random(seed));
            @(posedge mclk);
            // expectation taken while the write pulses still stand
            ew = exp_err(md, buf_st);
            buf_st.tx_wr <= 1'b0;
            buf_st.p1_wr <= 1'b0;
            @(negedge mclk);
            check("wr error", 32'(tx_write_error_flag), 32'(ew));
            repeat (3) settle();
            check("wr error held", 32'(tx_write_error_flag), 32'(ew));
        end

        // error event through status, mask and the combined interrupt
        bus(1'b1, `UFTS_ADDR_MODE_CTRL, 32'h0);
        bus(1'b1, `UFTS_ADDR_STATUS_HIGH, 32'h0);
        bus(1'b1, `UFTS_ADDR_IRQ_MASK, 32'h4);
        bus(1'b1, `UFTS_ADDR_IRQ_STATUS, 32'h4);
        settle();
        check("irq idle", 32'(irq), 32'h0);
        for (int k = 0; k < 2; k++) begin
            @(posedge mclk);
            buf_st.tx_count <= 4'h8;
            buf_st.tx_wr <= 1'b1;
            @(posedge mclk);
            buf_st.tx_wr <= 1'b0;
            settle();
            check("irq on error", 32'(irq), (k == 0) ? 32'h1 : 32'h0);
            check("flag on error", 32'(tx_write_error_flag), 32'h1);
            bus(1'b0, `UFTS_ADDR_IRQ_STATUS, 32'h0);
            check("irq status bit", rd & 32'h4, 32'h4);
            bus(1'b1, `UFTS_ADDR_STATUS_HIGH, 32'h0);
            bus(1'b1, `UFTS_ADDR_IRQ_STATUS, 32'h4);
            settle();
            check("irq cleared", 32'(irq), 32'h0);
            check("flag cleared", 32'(tx_write_error_flag), 32'h0);
            bus(1'b1, `UFTS_ADDR_IRQ_MASK, 32'h0);
        end
        complete_run();
    end
endmodule
